// *** pkg/spp_pkg.sv ***
// Shared constants of the serial peripheral port register block
package spp_pkg;

   // ------------------------------------------------------------------
   // Register addresses
   // ------------------------------------------------------------------
   localparam logic [7:0] SPP_ADDR_CONTROL = 8'hF8;
   localparam logic [7:0] SPP_ADDR_CONFIG = 8'h9A;
   localparam logic [7:0] SPP_ADDR_DATA = 8'h9B;
   localparam logic [7:0] SPP_ADDR_DIVIDER = 8'h9D;

   // ------------------------------------------------------------------
   // Configuration register fields
   // ------------------------------------------------------------------
   localparam int SPP_CFG_BUSY = 7;
   localparam int SPP_CFG_MASTER = 6;
   localparam int SPP_CFG_PHASE = 5;
   localparam int SPP_CFG_POLARITY = 4;
   localparam int SPP_CFG_SELECTED = 3;
   localparam int SPP_CFG_PIN_LEVEL = 2;
   localparam int SPP_CFG_SHIFT_EMPTY = 1;
   localparam int SPP_CFG_RX_EMPTY = 0;
   localparam logic [7:0] SPP_CFG_RESET = 8'h07;

   // ------------------------------------------------------------------
   // Control register fields
   // ------------------------------------------------------------------
   localparam int SPP_CTL_DONE = 7;
   localparam int SPP_CTL_COLLISION = 6;
   localparam int SPP_CTL_FAULT = 5;
   localparam int SPP_CTL_OVERRUN = 4;
   localparam int SPP_CTL_MODE_HI = 3;
   localparam int SPP_CTL_MODE_LO = 2;
   localparam int SPP_CTL_TX_EMPTY = 1;
   localparam int SPP_CTL_ENABLE = 0;
   localparam logic [7:0] SPP_CTL_RESET = 8'h06;

   localparam logic [7:0] SPP_DIV_RESET = 8'h00;
   localparam logic [7:0] SPP_DATA_RESET = 8'h00;

   // ------------------------------------------------------------------
   // Select pin modes and transfer geometry
   // ------------------------------------------------------------------
   localparam logic [1:0] SPP_MODE_3WIRE = 2'b00;
   localparam logic [1:0] SPP_MODE_4WIRE = 2'b01;
   localparam logic [2:0] SPP_LAST_BIT = 3'h7;
   localparam logic [3:0] SPP_LAST_EDGE = 4'hF;

   // Pin order in synchroniser vectors: select, miso, mosi, clock
   localparam logic [3:0] SPP_PIN_RESET = 4'h8;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int SPP_CLOCK_PERIOD_NS = 25;
   localparam int SPP_SELECT_SETUP_CLOCKS = 2;

   typedef enum logic [1:0] {
      SPP_M_IDLE = 2'b01,
      SPP_M_RUN = 2'b10
   } spp_mstate_e;

endpackage

// *** hw/spp_port.sv ***
// Serial peripheral port: registers, master clock generator and shift logic
// What this block does
// - Configuration register reads 0x07 after reset: pin mirror and both empty flags set.
// - Control register resets to 0x06: disabled, flags clear, mode 01, transmit empty.
// - Busy reads high throughout a byte transfer, master or slave.
// - Master enable 0 means slave, 1 means master driving the serial clock.
// - Phase 0 samples on the first clock edge, phase 1 on the second.
// - Polarity sets idle clock level: 0 idles low, 1 idles high.
// - A status bit mirrors the select pin level.
// - Shift empty sets when all data sent; clears on buffer write or a leading slave clock edge.
// - Receive empty sets when the buffer is read, clears when a byte arrives.
// - Transfer done sets at each byte end; only software clears it.
// - Data write while transmit buffer is full sets write collision.
// - Select pin low while master in mode 01 sets mode fault.
// - Slave byte completing while receive buffer unread sets overrun.
// - Mode 00 no pin, 01 pin is input, 1x pin driven with low bit.
// - Transmit empty drops on data write, rises when byte moves to shifter.
// - Enable bit switches the port off or on; select pin drive follows the mode bits alone.
// - Master clock is system clock over twice (divider plus one).
// - Data write fills transmit buffer and starts master transfer; read returns receive buffer.
// - A colliding data write is discarded.
// - Mode fault clears master enable and port enable.
// - On overrun the new byte is dropped and the old one kept.
// - Four-wire slave runs only with select low; its fall resets the bit counter.
`timescale 1ns/10ps
module spp_port (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   output logic spi_irq,
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe,
   input wire logic mosi_in,
   output logic mosi_out,
   output logic mosi_oe,
   input wire logic miso_in,
   output logic miso_out,
   output logic miso_oe,
   input wire logic select_in,
   output logic select_out,
   output logic select_oe
);
   import spp_pkg::*;

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   logic [3:0] pin_raw;
   logic [3:0] s1_r, s2_r, s3_r, pin_f_r, pin_f_nxt;
   assign pin_raw = {select_in, miso_in, mosi_in, sck_in};

   // A level counts once the second and third stages agree
   always_comb begin
      pin_f_nxt = (s2_r & s3_r) | (pin_f_r & (s2_r ^ s3_r));
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         s1_r <= SPP_PIN_RESET;
         s2_r <= SPP_PIN_RESET;
         s3_r <= SPP_PIN_RESET;
         pin_f_r <= SPP_PIN_RESET;
      end else begin
         s1_r <= pin_raw;
         s2_r <= s1_r;
         s3_r <= s2_r;
         pin_f_r <= pin_f_nxt;
      end
   end

   logic sck_f, mosi_f, miso_f, sel_f;
   assign {sel_f, miso_f, mosi_f, sck_f} = pin_f_r;

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   logic en_r, en_nxt, mst_r, mst_nxt, cpha_r, cpha_nxt, cpol_r, cpol_nxt;
   logic [1:0] mode_r, mode_nxt;
   logic done_r, done_nxt, write_collision_flag_r, write_collision_flag_nxt, mode_fault_flag_r, mode_fault_flag_nxt, ovr_r, ovr_nxt;
   logic tx_buffer_empty_r, tx_buffer_empty_nxt, rx_buffer_empty_r, rx_buffer_empty_nxt, shift_reg_empty_r, shift_reg_empty_nxt;
   logic busy_r, busy_nxt, sh_full_r, sh_full_nxt;
   logic [7:0] div_r, div_nxt, txbuf_r, txbuf_nxt, rxbuf_r, rxbuf_nxt;
   logic [7:0] sh_r, sh_nxt, rxsh_r, rxsh_nxt, divcnt_r, divcnt_nxt, rdata_nxt;
   logic [2:0] bitcnt_r, bitcnt_nxt;
   logic [3:0] edgecnt_r, edgecnt_nxt;
   spp_mstate_e mst_st_r, mst_st_nxt;
   logic sck_p_r, sel_p_r;
   logic sck_o_nxt, mosi_o_nxt, miso_o_nxt, irq_nxt;

   // ------------------------------------------------------------------
   // Decode and serial events
   // ------------------------------------------------------------------
   logic wr_ctl, wr_cfg, wr_div, wr_dat, rd_dat;
   logic s_act, s_tr, s_lead, m_tick, tr, lead, samp, drv, in_bit;
   logic done_ev, start_ev, fault_ev;

   assign wr_ctl = sfr_wr && (sfr_addr == SPP_ADDR_CONTROL);
   assign wr_cfg = sfr_wr && (sfr_addr == SPP_ADDR_CONFIG);
   assign wr_div = sfr_wr && (sfr_addr == SPP_ADDR_DIVIDER);
   assign wr_dat = sfr_wr && (sfr_addr == SPP_ADDR_DATA);
   assign rd_dat = sfr_rd && (sfr_addr == SPP_ADDR_DATA);

   // Four-wire slave listens only while select is low
   assign s_act = en_r && !mst_r && ((mode_r != SPP_MODE_4WIRE) || !sel_f);
   assign s_tr = s_act && (sck_f != sck_p_r);
   assign s_lead = (sck_f != cpol_r);
   assign m_tick = (mst_st_r == SPP_M_RUN) && (divcnt_r == div_r);
   assign tr = mst_r ? m_tick : s_tr;
   assign lead = mst_r ? !edgecnt_r[0] : s_lead;
   assign samp = tr && (lead ^ cpha_r);
   assign drv = tr && !(lead ^ cpha_r);
   assign in_bit = mst_r ? miso_f : mosi_f;
   assign done_ev = samp && (bitcnt_r == SPP_LAST_BIT);
   assign start_ev = (mst_st_r == SPP_M_IDLE) && en_r && mst_r && !tx_buffer_empty_r;
   assign fault_ev = en_r && mst_r && (mode_r == SPP_MODE_4WIRE) && !sel_f;

   // ------------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------------
   always_comb begin
      en_nxt = en_r;
      mst_nxt = mst_r;
      cpha_nxt = cpha_r;
      cpol_nxt = cpol_r;
      mode_nxt = mode_r;
      done_nxt = done_r;
      write_collision_flag_nxt = write_collision_flag_r;
      mode_fault_flag_nxt = mode_fault_flag_r;
      ovr_nxt = ovr_r;
      tx_buffer_empty_nxt = tx_buffer_empty_r;
      rx_buffer_empty_nxt = rx_buffer_empty_r;
      shift_reg_empty_nxt = shift_reg_empty_r;
      sh_full_nxt = sh_full_r;
      div_nxt = div_r;
      txbuf_nxt = txbuf_r;
      rxbuf_nxt = rxbuf_r;
      sh_nxt = sh_r;
      rxsh_nxt = rxsh_r;
      bitcnt_nxt = bitcnt_r;
      edgecnt_nxt = edgecnt_r;
      divcnt_nxt = divcnt_r;
      mst_st_nxt = mst_st_r;
      sck_o_nxt = sck_out;
      rdata_nxt = sfr_rdata;

      // Software writes first so hardware sets below win
      if (wr_cfg) begin
         mst_nxt = sfr_wdata[SPP_CFG_MASTER];
         cpha_nxt = sfr_wdata[SPP_CFG_PHASE];
         cpol_nxt = sfr_wdata[SPP_CFG_POLARITY];
      end
      if (wr_div) begin
         div_nxt = sfr_wdata;
      end
      if (wr_ctl) begin
         done_nxt = sfr_wdata[SPP_CTL_DONE];
         write_collision_flag_nxt = sfr_wdata[SPP_CTL_COLLISION];
         mode_fault_flag_nxt = sfr_wdata[SPP_CTL_FAULT];
         ovr_nxt = sfr_wdata[SPP_CTL_OVERRUN];
         mode_nxt = sfr_wdata[SPP_CTL_MODE_HI:SPP_CTL_MODE_LO];
         en_nxt = sfr_wdata[SPP_CTL_ENABLE];
      end
      if (wr_dat) begin
         if (!tx_buffer_empty_r) begin
            write_collision_flag_nxt = 1'b1;
         end else begin
            txbuf_nxt = sfr_wdata;
            tx_buffer_empty_nxt = 1'b0;
            shift_reg_empty_nxt = 1'b0;
         end
      end
      if (rd_dat) begin
         rx_buffer_empty_nxt = 1'b1;
      end

      // Shift engine shared by master and slave
      if (samp) begin
         rxsh_nxt = {rxsh_r[6:0], in_bit};
         bitcnt_nxt = bitcnt_r + 3'h1;
      end
      if (drv && (bitcnt_r != 3'h0)) begin
         sh_nxt = {sh_r[6:0], 1'b0};
      end
      // Only a leading edge opens a new bit; the closing edge of a byte keeps it set
      if (s_tr && s_lead) begin
         shift_reg_empty_nxt = 1'b0;
      end
      if (done_ev) begin
         done_nxt = 1'b1;
         sh_full_nxt = 1'b0;
         shift_reg_empty_nxt = tx_buffer_empty_r && !wr_dat;
         if (!mst_r && !rx_buffer_empty_r) begin
            ovr_nxt = 1'b1;
         end else begin
            rxbuf_nxt = rxsh_nxt;
            rx_buffer_empty_nxt = 1'b0;
         end
      end
      if (mode_r == SPP_MODE_4WIRE && sel_p_r && !sel_f) begin
         bitcnt_nxt = 3'h0;
      end

      // Slave preloads the shifter whenever it is idle and empty
      if (!mst_r && en_r && !sh_full_r && !tx_buffer_empty_r && !busy_r) begin
         sh_nxt = txbuf_r;
         sh_full_nxt = 1'b1;
         tx_buffer_empty_nxt = 1'b1;
      end

      // Master sequencer: sixteen clock edges per byte
      unique case (mst_st_r)
         SPP_M_IDLE: begin
            sck_o_nxt = cpol_r;
            if (start_ev) begin
               sh_nxt = txbuf_r;
               tx_buffer_empty_nxt = 1'b1;
               bitcnt_nxt = 3'h0;
               edgecnt_nxt = 4'h0;
               divcnt_nxt = 8'h00;
               mst_st_nxt = SPP_M_RUN;
            end
         end
         SPP_M_RUN: begin
            if (m_tick) begin
               divcnt_nxt = 8'h00;
               sck_o_nxt = !sck_out;
               edgecnt_nxt = edgecnt_r + 4'h1;
               if (edgecnt_r == SPP_LAST_EDGE) begin
                  mst_st_nxt = SPP_M_IDLE;
               end
            end else begin
               divcnt_nxt = divcnt_r + 8'h01;
            end
         end
      endcase

      // Mode fault releases the bus
      if (fault_ev) begin
         mode_fault_flag_nxt = 1'b1;
         mst_nxt = 1'b0;
         en_nxt = 1'b0;
      end

      // Busy: master while sequencing, slave from first leading edge to byte end
      if (mst_r) begin
         busy_nxt = (mst_st_nxt == SPP_M_RUN);
      end else begin
         busy_nxt = (busy_r || (s_tr && s_lead)) && !done_ev && s_act;
      end

      // A disabled port drops any transfer in flight
      if (!en_r) begin
         bitcnt_nxt = 3'h0;
         busy_nxt = 1'b0;
         mst_st_nxt = SPP_M_IDLE;
         sck_o_nxt = cpol_r;
      end

      mosi_o_nxt = sh_nxt[7];
      miso_o_nxt = sh_nxt[7];
      irq_nxt = done_nxt || write_collision_flag_nxt || mode_fault_flag_nxt || ovr_nxt;

      if (sfr_rd) begin
         unique case (sfr_addr)
            SPP_ADDR_CONFIG: rdata_nxt = {busy_r, mst_r, cpha_r, cpol_r, !sel_f, sel_f, shift_reg_empty_r, rx_buffer_empty_r};
            SPP_ADDR_CONTROL: rdata_nxt = {done_r, write_collision_flag_r, mode_fault_flag_r, ovr_r, mode_r, tx_buffer_empty_r, en_r};
            SPP_ADDR_DIVIDER: rdata_nxt = div_r;
            SPP_ADDR_DATA: rdata_nxt = rxbuf_r;
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         {busy_r, mst_r, cpha_r, cpol_r} <= SPP_CFG_RESET[7:4];
         shift_reg_empty_r <= SPP_CFG_RESET[SPP_CFG_SHIFT_EMPTY];
         rx_buffer_empty_r <= SPP_CFG_RESET[SPP_CFG_RX_EMPTY];
         {done_r, write_collision_flag_r, mode_fault_flag_r, ovr_r} <= SPP_CTL_RESET[7:4];
         mode_r <= SPP_CTL_RESET[SPP_CTL_MODE_HI:SPP_CTL_MODE_LO];
         tx_buffer_empty_r <= SPP_CTL_RESET[SPP_CTL_TX_EMPTY];
         en_r <= SPP_CTL_RESET[SPP_CTL_ENABLE];
         div_r <= SPP_DIV_RESET;
         txbuf_r <= SPP_DATA_RESET;
         rxbuf_r <= SPP_DATA_RESET;
         sh_r <= SPP_DATA_RESET;
         rxsh_r <= SPP_DATA_RESET;
         sh_full_r <= 1'b0;
         bitcnt_r <= 3'h0;
         edgecnt_r <= 4'h0;
         divcnt_r <= 8'h00;
         mst_st_r <= SPP_M_IDLE;
         sck_p_r <= SPP_PIN_RESET[0];
         sel_p_r <= SPP_PIN_RESET[3];
         sfr_rdata <= 8'h00;
         spi_irq <= 1'b0;
         sck_out <= 1'b0;
         sck_oe <= 1'b0;
         mosi_out <= 1'b0;
         mosi_oe <= 1'b0;
         miso_out <= 1'b0;
         miso_oe <= 1'b0;
         select_out <= 1'b0;
         select_oe <= 1'b0;
      end else begin
         {busy_r, mst_r, cpha_r, cpol_r} <= {busy_nxt, mst_nxt, cpha_nxt, cpol_nxt};
         shift_reg_empty_r <= shift_reg_empty_nxt;
         rx_buffer_empty_r <= rx_buffer_empty_nxt;
         {done_r, write_collision_flag_r, mode_fault_flag_r, ovr_r} <= {done_nxt, write_collision_flag_nxt, mode_fault_flag_nxt, ovr_nxt};
         mode_r <= mode_nxt;
         tx_buffer_empty_r <= tx_buffer_empty_nxt;
         en_r <= en_nxt;
         div_r <= div_nxt;
         txbuf_r <= txbuf_nxt;
         rxbuf_r <= rxbuf_nxt;
         sh_r <= sh_nxt;
         rxsh_r <= rxsh_nxt;
         sh_full_r <= sh_full_nxt;
         bitcnt_r <= bitcnt_nxt;
         edgecnt_r <= edgecnt_nxt;
         divcnt_r <= divcnt_nxt;
         mst_st_r <= mst_st_nxt;
         sck_p_r <= sck_f;
         sel_p_r <= sel_f;
         sfr_rdata <= rdata_nxt;
         spi_irq <= irq_nxt;
         sck_out <= sck_o_nxt;
         sck_oe <= en_nxt && mst_nxt;
         mosi_out <= mosi_o_nxt;
         mosi_oe <= en_nxt && mst_nxt;
         miso_out <= miso_o_nxt;
         miso_oe <= s_act;
         select_out <= mode_nxt[0];
         select_oe <= mode_nxt[1];
      end
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   sequence s_master_start;
      start_ev ##1 (mst_st_r == SPP_M_RUN);
   endsequence

   a_reset_values: assert property ($rose(rst_b) |->
      ({busy_r, mst_r, cpha_r, cpol_r, !sel_f, sel_f, shift_reg_empty_r, rx_buffer_empty_r} == SPP_CFG_RESET) &&
      ({done_r, write_collision_flag_r, mode_fault_flag_r, ovr_r, mode_r, tx_buffer_empty_r, en_r} == SPP_CTL_RESET))
      else $error("register values wrong after reset");
   a_busy_master: assert property (s_master_start |-> busy_r && tx_buffer_empty_r)
      else $error("master start did not raise busy or empty the buffer");
   a_collision_drop: assert property (wr_dat && !tx_buffer_empty_r |=> write_collision_flag_r && (txbuf_r == $past(txbuf_r)))
      else $error("colliding write not flagged or not discarded");
   a_tx_write: assert property (wr_dat && tx_buffer_empty_r |=> !shift_reg_empty_r && (txbuf_r == $past(sfr_wdata)))
      else $error("data write did not fill the transmit buffer");
   a_fault_release: assert property (fault_ev |=> mode_fault_flag_r && !en_r && !mst_r)
      else $error("mode fault did not release the bus");
   a_overrun_keep: assert property (done_ev && !mst_r && !rx_buffer_empty_r |=> ovr_r && (rxbuf_r == $past(rxbuf_r)))
      else $error("overrun overwrote the receive buffer");
   a_done_flag: assert property (done_ev |=> done_r ##1 spi_irq)
      else $error("byte end did not set the done flag and request");
   a_clock_rate: assert property (m_tick && en_r && (div_r != 8'h00) |=>
      (sck_out != $past(sck_out)) ##1 (sck_out == $past(sck_out)))
      else $error("serial clock did not toggle on divider wrap");
   a_idle_level: assert property ((en_r && mst_r && mst_st_r == SPP_M_IDLE)[*2] |-> sck_out == cpol_r)
      else $error("serial clock not at idle level");
   a_read_data: assert property (rd_dat && !done_ev |=> (sfr_rdata == $past(rxbuf_r)) && rx_buffer_empty_r)
      else $error("data read returned wrong byte or left buffer full");
endmodule

// *** verif/spp_partner.sv ***
// Far-side serial device: a slave that answers the port, or a master that drives it
`timescale 1ns/10ps
module spp_partner (
   input wire logic clock,
   input wire logic sck,
   input wire logic mosi,
   input wire logic miso,
   input wire logic pol,
   input wire logic pha,
   output logic miso_drv,
   output logic sck_drv,
   output logic mosi_drv,
   output logic select_b_drv
);
   logic [7:0] tx = 8'h00;
   logic [7:0] rx = 8'h00;
   logic skip = 1'b0;
   int cnt = 0;
   logic [7:0] q[$];
   logic [7:0] got[$];
   assign miso_drv = tx[7];
   initial begin
      sck_drv = 1'b0;
      mosi_drv = 1'b0;
      select_b_drv = 1'b1;
   end
   // ------------------------------------------------------------------
   // Slave side: sample edge chosen by phase and polarity
   // ------------------------------------------------------------------
   always @(sck) begin
      if ((sck ^ pol ^ pha) === 1'b1) begin
         rx = {rx[6:0], mosi};
         cnt++;
         if (cnt == 8) begin
            got.push_back(rx);
            cnt = 0;
            if (pha && q.size() > 0) begin
               tx = q.pop_front();
               skip = 1'b1;
            end
         end
      end else if (skip) begin
         skip = 1'b0;
      end else if (cnt == 0 && !pha && q.size() > 0) begin
         tx = q.pop_front();
      end else begin
         tx = {tx[6:0], ~tx[7]};
      end
   end
   task load(input logic [7:0] a, input logic [7:0] b);
      q.delete();
      got.delete();
      q.push_back(b);
      tx = a;
      cnt = 0;
      skip = pha;
   endtask
   task set_select(input logic v);
      select_b_drv = v;
   endtask
   // Master side, MSB first, half period of 6 clocks
   task drive(input logic [7:0] d, input int n, output logic [7:0] c);
      int i;
      c = 8'h00;
      repeat (6) @(posedge clock);
      #1 select_b_drv = 1'b0;
      for (i = 7; i > 7 - n; i--) begin
         mosi_drv = d[i];
         repeat (6) @(posedge clock);
         #1 sck_drv = 1'b1;
         c[i] = miso;
         repeat (6) @(posedge clock);
         #1 sck_drv = 1'b0;
      end
      repeat (6) @(posedge clock);
      #1 select_b_drv = 1'b1;
      mosi_drv = ~mosi_drv;
   endtask
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the serial peripheral port
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module testbench;
   import spp_pkg::*;
   localparam logic [7:0] A_CTL = SPP_ADDR_CONTROL;
   localparam logic [7:0] A_CFG = SPP_ADDR_CONFIG;
   localparam logic [7:0] A_DAT = SPP_ADDR_DATA;
   localparam logic [7:0] A_DIV = SPP_ADDR_DIVIDER;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] sfr_addr = 8'h00;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic pol = 1'b0;
   logic pha = 1'b0;
   logic [7:0] sfr_rdata, v, c;
   logic spi_irq, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, select_out, select_oe, s;
   logic miso_drv, sck_drv, mosi_drv, select_b_drv;
   wire sck_w = sck_oe ? sck_out : sck_drv;
   wire mosi_w = mosi_oe ? mosi_out : mosi_drv;
   wire miso_w = miso_oe ? miso_out : miso_drv;
   wire sel_w = select_oe ? select_out : select_b_drv;
   int n_mismatch = 0;
   int checks = 0;
   int n, k, m;
   always #12.5 clock = ~clock;
   spp_port spp_port_i (.clock(clock), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .spi_irq(spi_irq), .sck_in(sck_w), .sck_out(sck_out),
      .sck_oe(sck_oe), .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w),
      .miso_out(miso_out), .miso_oe(miso_oe), .select_in(sel_w), .select_out(select_out), .select_oe(select_oe));
   spp_partner spp_partner_i (.clock(clock), .sck(sck_w), .mosi(mosi_w), .miso(miso_w), .pol(pol), .pha(pha),
      .miso_drv(miso_drv), .sck_drv(sck_drv), .mosi_drv(mosi_drv), .select_b_drv(select_b_drv));
   // ------------------------------------------------------------------
   // Bus and helper tasks
   // ------------------------------------------------------------------
   task tick(input int t);
      repeat (t) @(posedge clock);
      #1;
   endtask
   task do_reset();
      rst_b = 1'b0;
      tick(6);
      rst_b = 1'b1;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      tick(1);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      tick(1);
      sfr_wr = 1'b0;
   endtask
   task rchk(input logic [7:0] a, input logic [7:0] mk, input logic [7:0] e, input string nm);
      tick(1);
      sfr_addr = a;
      sfr_rd = 1'b1;
      tick(1);
      sfr_rd = 1'b0;
      v = sfr_rdata;
      `CHK(nm, e, v & mk)
   endtask
   task wait_got(input int nb);
      for (k = 0; k < 400 && spp_partner_i.got.size() < nb; k++) tick(1);
      tick(8);
   endtask
   task tally_and_finish();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task t_reset();
      rchk(A_CFG, 8'hFF, SPP_CFG_RESET, "config");
      rchk(A_CTL, 8'hFF, SPP_CTL_RESET, "control");
      rchk(A_DAT, 8'hFF, 8'h00, "data");
      rchk(8'h55, 8'hFF, 8'h00, "unmapped");
      `CHK("select_oe", 1'b0, select_oe)
      $display("done: reset values");
   endtask
   task t_master();
      do_reset();
      wr(A_DIV, 8'h04);
      wr(A_CFG, 8'h40);
      wr(A_CTL, 8'h01);
      spp_partner_i.load(8'h5A, 8'h96);
      wr(A_DAT, 8'hA5);
      s = sck_out;
      for (n = 0; n < 40 && sck_out === s; n++) tick(1);
      s = sck_out;
      for (n = 0; n < 40 && sck_out === s; n++) tick(1);
      `CHK("half period", 8'h04 + 1, n)
      `CHK("sck_oe", 1'b1, sck_oe)
      `CHK("mosi_oe", 1'b1, mosi_oe)
      rchk(A_CFG, 8'h80, 8'h80, "busy");
      wr(A_DAT, 8'h3C);
      rchk(A_CTL, 8'h02, 8'h00, "tx empty");
      wr(A_DAT, 8'hE7);
      wait_got(2);
      `CHK("sent 1", 8'hA5, spp_partner_i.got[0])
      `CHK("sent 2", 8'h3C, spp_partner_i.got[1])
      rchk(A_DAT, 8'hFF, 8'h96, "rx data");
      rchk(A_CTL, 8'hFF, 8'hC3, "flags");
      rchk(A_CFG, 8'h80, 8'h00, "idle");
      `CHK("irq", 1'b1, spi_irq)
      wr(A_CTL, 8'h01);
      rchk(A_CTL, 8'hFF, 8'h03, "cleared");
      tick(2);
      `CHK("irq off", 1'b0, spi_irq)
      $display("done: master transfer");
   endtask
   task t_modes();
      for (m = 1; m < 4; m++) begin
         {pol, pha} = m[1:0];
         do_reset();
         wr(A_DIV, 8'h04);
         wr(A_CFG, {2'b01, pha, pol, 4'h0});
         wr(A_CTL, 8'h01);
         tick(3);
         `CHK("idle sck", pol, sck_out)
         spp_partner_i.load({6'h21, m[1:0]}, 8'h00);
         wr(A_DAT, {6'h0C, m[1:0]});
         wait_got(1);
         `CHK("mode tx", {6'h0C, m[1:0]}, spp_partner_i.got[0])
         rchk(A_DAT, 8'hFF, {6'h21, m[1:0]}, "mode rx");
      end
      {pol, pha} = 2'b00;
      $display("done: clock modes");
   endtask
   task t_select();
      do_reset();
      wr(A_CTL, 8'h0D);
      tick(2);
      `CHK("sel drive", 2'b11, {select_oe, select_out})
      tick(6);
      rchk(A_CFG, 8'h0C, 8'h04, "pin high");
      wr(A_CTL, 8'h09);
      tick(6);
      `CHK("sel low", 1'b0, select_out)
      rchk(A_CFG, 8'h0C, 8'h08, "pin low");
      wr(A_CTL, 8'h01);
      tick(2);
      `CHK("sel off", 1'b0, select_oe)
      $display("done: select modes");
   endtask
   task t_fault();
      do_reset();
      wr(A_CFG, 8'h40);
      wr(A_CTL, 8'h05);
      tick(2);
      spp_partner_i.set_select(1'b0);
      tick(8);
      rchk(A_CTL, 8'hFF, 8'h26, "fault");
      rchk(A_CFG, 8'h40, 8'h00, "master off");
      `CHK("fault irq", 1'b1, spi_irq)
      `CHK("sck released", 1'b0, sck_oe)
      spp_partner_i.set_select(1'b1);
      $display("done: mode fault");
   endtask
   task t_slave();
      do_reset();
      wr(A_CTL, 8'h05);
      tick(6);
      rchk(A_CFG, 8'hFF, 8'h07, "slave idle");
      wr(A_DAT, 8'h3C);
      rchk(A_CFG, 8'h02, 8'h00, "shift full");
      spp_partner_i.drive(8'hC3, 8, c);
      `CHK("slave tx", 8'h3C, c)
      tick(6);
      rchk(A_CTL, 8'hFF, 8'h87, "slave done");
      rchk(A_CFG, 8'hFF, 8'h06, "slave status");
      spp_partner_i.drive(8'h11, 8, c);
      tick(6);
      rchk(A_CTL, 8'hFF, 8'h97, "overrun");
      rchk(A_DAT, 8'hFF, 8'hC3, "kept byte");
      rchk(A_CFG, 8'h01, 8'h01, "rx empty");
      spp_partner_i.drive(8'hF0, 3, c);
      spp_partner_i.drive(8'h5A, 8, c);
      tick(6);
      rchk(A_DAT, 8'hFF, 8'h5A, "count restart");
      `CHK("miso idle", 1'b0, miso_oe)
      $display("done: slave transfer");
   endtask
   initial begin
      do_reset();
      t_reset();
      t_master();
      t_modes();
      t_select();
      t_fault();
      t_slave();
      tally_and_finish();
   end
   initial begin
      #(25 * 20000);
      n_mismatch++;
      $display("watchdog expired");
      tally_and_finish();
   end
endmodule
